// >>> inc/sac_params.svh
// Constants of the converter control block: register offsets, fields, reset values, timing.
// Included by the package and the design; holds definitions only.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
`define SAC_ADDR_W          16
`define SAC_OFS_MODE        16'hFFC4
`define SAC_OFS_RESULT      16'hFFC5
`define SAC_OFS_START       16'hFFC6
`define SAC_OFS_IRQ_STATUS  16'hFFC7
`define SAC_OFS_IRQ_MASK    16'hFFC8
`define SAC_MODE_RESET      8'h30
`define SAC_MODE_RSVD       8'h30
`define SAC_MODE_WMASK      8'hCF
`define SAC_START_RSVD      8'h7F
`define SAC_BIT_SPEED       7
`define SAC_BIT_TRIG_EN     6
`define SAC_BIT_START       7
`define SAC_CH_HI           3
`define SAC_CH_LO           0
`define SAC_PERIOD_SLOW     6'd62
`define SAC_PERIOD_FAST     6'd31
`define SAC_CNT_W           6
`define SAC_CNT_ONE         6'h01
`define SAC_CNT_ZERO        6'h00
`define SAC_SAMPLE_CYCLES   6'h04
`define SAC_BIT_SHIFT_SLOW  6'h06
`define SAC_BIT_SHIFT_FAST  6'h02
`define SAC_READ_UNMAPPED   8'h00
`endif

// >>> inc/sac_pkg.sv
// Types shared by the converter control block.
// Assumes sac_params.svh sits on the include path.
`include "sac_params.svh"
package sac_pkg;
  typedef logic [7:0]                data_t;
  typedef logic [`SAC_ADDR_W-1:0]    addr_t;
  typedef logic [3:0]                chan_code_t;
  typedef enum logic [2:0]
  {
    SAC_IDLE   = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_DECIDE = 3'b100
  } sac_state_t;
endpackage

// >>> verilog/sac_adc_control.sv
// Control of an 8-bit, eight-channel successive-approximation converter.
// Assumes an analog ladder and comparator outside, driven from dac_code_o and sample_o.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_adc_control
  import sac_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           reset_n_i,
  input  wire sac_pkg::addr_t addr_i,
  input  wire sac_pkg::data_t wdata_i,
  input  wire logic           wr_i,
  input  wire logic           rd_i,
  output sac_pkg::data_t      rdata_o,
  input  wire logic           ext_trigger_pin_i,
  input  wire logic           trigger_edge_select_i,
  input  wire logic           comparator_i,
  output logic [7:0]          channel_enable_o,
  output logic                sample_o,
  output sac_pkg::data_t      dac_code_o,
  output logic                conv_done_o,
  output logic                irq_o
);
  import sac_pkg::*;

  logic [1:0]        rst_sync;
  logic              rst_n;
  logic [1:0]        trig_sync;
  logic              trig_q;
  data_t             conversion_mode;
  data_t             conversion_result;
  logic              start_flag;
  logic              conv_done_request;
  logic              conv_done_irq_enable;
  sac_state_t        state;
  sac_state_t        next_state;
  logic [`SAC_CNT_W-1:0] period_cnt;
  logic [`SAC_CNT_W-1:0] bit_cnt;
  logic [2:0]        bit_idx;
  data_t             sar;

  // Chain of two flops; only the second stage feeds the design.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // The trigger pin is asynchronous; trig_sync[0] feeds only trig_sync[1].
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_sync <= 2'h0;
      trig_q    <= 1'b0;
    end
    else
    begin
      trig_sync <= {trig_sync[0], ext_trigger_pin_i};
      trig_q    <= trig_sync[1];
    end
  end

  function automatic logic [7:0] chan_decode(input chan_code_t code);
    logic [7:0] onehot;
    onehot = 8'h00;
    case (code[3:2])
      2'b01:   onehot[{1'b0, code[1:0]}] = 1'b1;
      2'b10:   onehot[{1'b1, code[1:0]}] = 1'b1;
      default: onehot = 8'h00;
    endcase
    return onehot;
  endfunction

  // Register decode.
  wire sel_mode   = (addr_i == `SAC_OFS_MODE);
  wire sel_result = (addr_i == `SAC_OFS_RESULT);
  wire sel_start  = (addr_i == `SAC_OFS_START);
  wire sel_status = (addr_i == `SAC_OFS_IRQ_STATUS);
  wire sel_mask   = (addr_i == `SAC_OFS_IRQ_MASK);
  wire wr_mode    = wr_i & sel_mode;
  wire wr_start   = wr_i & sel_start;
  wire sw_start   = wr_start & wdata_i[`SAC_BIT_START];
  wire sw_stop    = wr_start & ~wdata_i[`SAC_BIT_START];

  // Polarity 1 selects the rising edge, 0 the falling edge.
  wire trig_rise  = trig_sync[1] & ~trig_q;
  wire trig_fall  = ~trig_sync[1] & trig_q;
  wire trig_edge  = trigger_edge_select_i ? trig_rise : trig_fall;
  wire hw_start   = conversion_mode[`SAC_BIT_TRIG_EN] & trig_edge;
  wire go         = (sw_start | hw_start) & ~start_flag;

  wire speed_fast = conversion_mode[`SAC_BIT_SPEED];
  wire [`SAC_CNT_W-1:0] period_len =
    speed_fast ? `SAC_PERIOD_FAST : `SAC_PERIOD_SLOW;
  wire [`SAC_CNT_W-1:0] bit_len =
    speed_fast ? `SAC_BIT_SHIFT_FAST : `SAC_BIT_SHIFT_SLOW;
  wire period_end = start_flag & (period_cnt == period_len);
  wire bit_end    = (bit_cnt == bit_len);
  wire abort      = sw_stop & start_flag;
  wire finish     = period_end & ~abort;

  always_comb
  begin
    next_state = state;
    case (state)
      SAC_IDLE:   if (go) next_state = SAC_SAMPLE;
      SAC_SAMPLE: if (abort) next_state = SAC_IDLE;
                  else if (bit_cnt == `SAC_SAMPLE_CYCLES) next_state = SAC_DECIDE;
      SAC_DECIDE: if (abort | finish) next_state = SAC_IDLE;
      default:    next_state = SAC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= SAC_IDLE;
    else
      state <= next_state;
  end

  // Mode register: reserved bits are forced high and never stored from the bus.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      conversion_mode <= `SAC_MODE_RESET;
    else if (wr_mode)
      conversion_mode <= (wdata_i & `SAC_MODE_WMASK) | `SAC_MODE_RSVD;
  end

  // Start flag, set by software or trigger, cleared at finish or on stop.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      start_flag <= 1'b0;
    else if (go)
      start_flag <= 1'b1;
    else if (finish | abort)
      start_flag <= 1'b0;
  end

  // Period counter runs from the set of the start flag to the selected length.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_cnt <= `SAC_CNT_ZERO;
      bit_cnt    <= `SAC_CNT_ZERO;
    end
    else if (go | ~start_flag)
    begin
      period_cnt <= `SAC_CNT_ONE;
      bit_cnt    <= `SAC_CNT_ZERO;
    end
    else
    begin
      period_cnt <= period_cnt + `SAC_CNT_ONE;
      if (state == SAC_SAMPLE && bit_cnt == `SAC_SAMPLE_CYCLES)
        bit_cnt <= `SAC_CNT_ZERO;
      else if (state == SAC_DECIDE && bit_end)
        bit_cnt <= `SAC_CNT_ZERO;
      else
        bit_cnt <= bit_cnt + `SAC_CNT_ONE;
    end
  end

  // Successive approximation: one decision per bit slot, MSB first.
  // Eight slots fit inside either period, so the last decision precedes the finish.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sar     <= 8'h00;
      bit_idx <= 3'h7;
    end
    else if (state == SAC_SAMPLE)
    begin
      sar     <= 8'h80;
      bit_idx <= 3'h7;
    end
    else if (state == SAC_DECIDE && bit_end && start_flag)
    begin
      sar[bit_idx] <= comparator_i;
      if (bit_idx != 3'h0)
      begin
        sar[bit_idx - 3'h1] <= 1'b1;
        bit_idx             <= bit_idx - 3'h1;
      end
    end
  end

  // No reset on the result: it keeps its value through a chip reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_n && finish)
      conversion_result <= sar;
  end

  // Interrupt status: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_done_request    <= 1'b0;
      conv_done_irq_enable <= 1'b0;
    end
    else
    begin
      if (finish)
        conv_done_request <= 1'b1;
      else if (wr_i && sel_status && wdata_i[0])
        conv_done_request <= 1'b0;
      if (wr_i && sel_mask)
        conv_done_irq_enable <= wdata_i[0];
    end
  end

  // Read data one cycle after the strobe; the result is readable at any time.
  wire [7:0] read_mux =
    sel_mode   ? conversion_mode :
    sel_result ? conversion_result :
    sel_start  ? {start_flag, 7'h00} | `SAC_START_RSVD :
    sel_status ? {7'h00, conv_done_request} :
    sel_mask   ? {7'h00, conv_done_irq_enable} : `SAC_READ_UNMAPPED;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_o          <= 8'h00;
      channel_enable_o <= 8'h00;
      sample_o         <= 1'b0;
      dac_code_o       <= 8'h00;
      conv_done_o      <= 1'b0;
      irq_o            <= 1'b0;
    end
    else
    begin
      rdata_o          <= rd_i ? read_mux : 8'h00;
      channel_enable_o <= chan_decode(conversion_mode[`SAC_CH_HI:`SAC_CH_LO]);
      sample_o         <= (next_state == SAC_SAMPLE);
      dac_code_o       <= sar;
      conv_done_o      <= finish;
      irq_o            <= (conv_done_request | finish) & conv_done_irq_enable;
    end
  end
endmodule // sac_adc_control

// >>> verification/sac_adc_props.sv
// Port checker for the converter control block, bound to its top module.
// Assumes one clock, clk_i, and the active-low reset reset_n_i.
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_adc_props
  import sac_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           reset_n_i,
  input  wire sac_pkg::addr_t addr_i,
  input  wire logic           wr_i,
  input  wire logic           rd_i,
  input  wire sac_pkg::data_t rdata_o,
  input  wire logic [7:0]     channel_enable_o,
  input  wire logic           conv_done_o,
  input  wire logic           irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_start_reserved_ones: assert property (rd_i && addr_i == `SAC_OFS_START
    |=> rdata_o[6:0] == 7'h7F) else $error("start register low bits not one");
  a_mode_reserved_ones: assert property (rd_i && addr_i == `SAC_OFS_MODE
    |=> rdata_o[5:4] == 2'h3) else $error("mode register bits 5 4 not one");
  a_unmapped_reads_zero: assert property (rd_i && (addr_i < `SAC_OFS_MODE ||
    addr_i > `SAC_OFS_IRQ_MASK) |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_done_single_pulse: assert property (conv_done_o |=> !conv_done_o)
    else $error("done pulse longer than one cycle");
  a_channel_one_hot: assert property ($onehot0(channel_enable_o))
    else $error("more than one input selected");
  a_irq_rise_cause: assert property ($rose(irq_o)
    |-> conv_done_o || $past(wr_i) || $past(wr_i, 2)) else $error("interrupt rose unprompted");
  a_irq_fall_cause: assert property ($fell(irq_o)
    |-> $past(wr_i) || $past(wr_i, 2)) else $error("interrupt fell without a write");
  c_done: cover property (conv_done_o);
  c_irq: cover property ($rose(irq_o));
  c_result_read: cover property (rd_i && addr_i == `SAC_OFS_RESULT);
endmodule // sac_adc_props
bind sac_adc_control sac_adc_props u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .channel_enable_o(channel_enable_o), .conv_done_o(conv_done_o), .irq_o(irq_o));

// >>> verification/sac_analog_model.sv
// Analog side: eight input levels and the comparator against the trial code.
// A level is taken half a step above its code, so a tie reads as above.
`timescale 1ns/10ps
module sac_analog_model
  import sac_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic [7:0]     channel_enable_i,
  input  wire sac_pkg::data_t dac_code_i,
  input  wire logic [63:0]    levels_i,
  output logic                comparator_o
);
  logic  wobble = 1'b0;
  data_t level;
  always_comb
  begin
    level = 8'h00;
    for (int i = 0; i < 8; i++)
      if (channel_enable_i[i]) level = levels_i[i*8 +: 8];
  end
  // With no input switched in the output wanders, so nothing may rely on it.
  always @(posedge clk_i) wobble <= !wobble;
  assign comparator_o = (channel_enable_i == 8'h00) ? wobble : (level >= dac_code_i);
endmodule // sac_analog_model

// >>> verification/sac_adc_control_tb_top.sv
// Self-checking bench for the converter control block with the analog model.
// Assumes the checker is bound by its own file.
`timescale 1ns/10ps
module sac_adc_control_tb_top;
  import sac_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        trig = 1'b0;
  logic        esel = 1'b1;
  logic        comp, done, irq;
  logic [7:0]  chen;
  logic [63:0] levels = 64'h0;
  addr_t       addr = 16'h0000;
  data_t       wdata = 8'h00;
  data_t       dac, rdata, v;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n, p, mk, hits;
  always #12.5 clk = ~clk;
  sac_adc_control uut (.clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_trigger_pin_i(trig),
    .trigger_edge_select_i(esel), .comparator_i(comp), .channel_enable_o(chen),
    .sample_o(), .dac_code_o(dac), .conv_done_o(done), .irq_o(irq));
  sac_analog_model adc (.clk_i(clk), .channel_enable_i(chen), .dac_code_i(dac),
    .levels_i(levels), .comparator_o(comp));
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk8(input string what, input data_t exp, input data_t got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr_reg(input addr_t a, input data_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input addr_t a, input data_t exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk8($sformatf("reg %h", a), exp, rdata);
  endtask
  task wait_done(inout int k);
    while (done !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  task edge_to(input logic lvl, input data_t exp);
    @(posedge clk) trig <= lvl;
    repeat (8) @(posedge clk);
    rd_chk(16'hFFC6, exp);
  endtask
  function automatic data_t code_of(input int ch);
    return (ch < 4) ? data_t'(8'h04 + ch) : data_t'(8'h04 + ch);
  endfunction
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      print_verdict;
    end
  end
  initial
  begin
    v = data_t'($urandom(32'h0D805842));
    levels = {8'hFF, $urandom, 16'($urandom), 8'h00};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(16'hFFC4, 8'h30);
    rd_chk(16'hFFC6, 8'h7F);
    rd_chk(16'hFFC9, 8'h00);
    wr_reg(16'hFFC4, 8'h00);
    rd_chk(16'hFFC4, 8'h30);
    wr_reg(16'hFFC4, 8'hCC | {6'h00, v[1:0]});
    rd_chk(16'hFFC4, 8'hFC | {6'h00, v[1:0]});
    chk8("reserved channel", 8'h00, chen);
    wr_reg(16'hFFC6, 8'h00);
    rd_chk(16'hFFC6, 8'h7F);
    $display("test registers done");
    for (int ch = 0; ch < 8; ch++)
    begin
      p = (ch % 2) ? 31 : 62;
      mk = $urandom % 2;
      wr_reg(16'hFFC8, data_t'(mk));
      wr_reg(16'hFFC4, {ch % 2 == 1, 3'b011, 4'(code_of(ch))});
      wr_reg(16'hFFC6, 8'h80);
      rd_chk(16'hFFC6, 8'hFF);
      chk8("channel", data_t'(1 << ch), chen);
      n = 3;
      wait_done(n);
      chk8("period", 8'h01, data_t'(n == p + 1 || n == p + 2));
      rd_chk(16'hFFC5, levels[ch*8 +: 8]);
      rd_chk(16'hFFC6, 8'h7F);
      chk8("irq", data_t'(mk), {7'h00, irq});
      rd_chk(16'hFFC7, 8'h01);
      wr_reg(16'hFFC7, 8'h01);
      rd_chk(16'hFFC7, 8'h00);
      chk8("irq clear", 8'h00, {7'h00, irq});
    end
    $display("test conversions done");
    // A reset after the last conversion, while idle, must leave its result in place.
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(16'hFFC5, levels[63:56]);
    rd_chk(16'hFFC4, 8'h30);
    $display("test reset done");
    wr_reg(16'hFFC6, 8'h80);
    repeat (10) @(posedge clk);
    wr_reg(16'hFFC6, 8'h00);
    rd_chk(16'hFFC6, 8'h7F);
    hits = 0;
    repeat (80) @(negedge clk) hits += (done === 1'b1);
    chk8("aborted done", 8'h00, data_t'(hits));
    rd_chk(16'hFFC7, 8'h00);
    $display("test abort done");
    wr_reg(16'hFFC4, 8'h38);
    edge_to(1'b1, 8'h7F);
    @(posedge clk) trig <= 1'b0;
    wr_reg(16'hFFC4, 8'h78);
    edge_to(1'b1, 8'hFF);
    n = 0;
    wait_done(n);
    rd_chk(16'hFFC5, levels[39:32]);
    @(posedge clk) esel <= 1'b0;
    edge_to(1'b0, 8'hFF);
    n = 0;
    wait_done(n);
    edge_to(1'b1, 8'h7F);
    $display("test trigger done");
    print_verdict;
  end
endmodule // sac_adc_control_tb_top
